// [design/pio_wr_device.sv]
// device end of the host write port with its transmit word fifo
`timescale 1ns/10ps
`default_nettype none
`include "pio_wr_map.svh"

// ************************************************************
// transmit word fifo
// ************************************************************
module tx_word_fifo #(
    parameter int WIDTH = `PIO_DATA_W,
    parameter int DEPTH = `PIO_FIFO_DEPTH
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
        logic                        out_valid;
        logic [WIDTH-1:0]            out_data;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic        push;
    logic        pop;

    assign in_ready_o  = (s_q.count != FULL_CNT);
    assign out_valid_o = s_q.out_valid;
    assign out_data_o  = s_q.out_data;

    always_comb begin
        s_d  = s_q;
        push = in_valid_i && in_ready_o;
        pop  = (s_q.count != '0) && (!s_q.out_valid || out_ready_i);
        if (out_ready_i) begin
            s_d.out_valid = 1'b0;
        end
        if (push) begin
            s_d.mem[s_q.wr_ptr] = in_data_i;
            s_d.wr_ptr = (s_q.wr_ptr == LAST_PTR) ? '0 : s_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_d.out_valid = 1'b1;
            s_d.out_data  = s_q.mem[s_q.rd_ptr];
            s_d.rd_ptr = (s_q.rd_ptr == LAST_PTR) ? '0 : s_q.rd_ptr + 1'b1;
        end
        s_d.count = s_q.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // tx_word_fifo

// ************************************************************
// device end
// ************************************************************
module pio_wr_device (
    input  wire logic                sys_clk_i,
    input  wire logic                rst_b_i,
    pio_wr_if.device                 pins,
    output logic                     reg_wr_o,
    output pio_wr_pkg::addr_t        reg_addr_o,
    output pio_wr_pkg::word_t        reg_data_o,
    output logic                     tx_valid_o,
    input  wire logic                tx_ready_i,
    output pio_wr_pkg::word_t        tx_data_o,
    output logic                     fifo_full_o,
    output logic                     overrun_o
);
    import pio_wr_pkg::*;

    localparam int PIN_W = 3 + `PIO_ADDR_W + `PIO_DATA_W;
    localparam int SH_W  = 1 + `PIO_ADDR_W + `PIO_DATA_W;

    typedef struct packed {
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic             active;
        logic [SH_W-1:0]  shadow;
        logic             reg_wr;
        addr_t            reg_addr;
        word_t            reg_data;
        logic             push;
        word_t            push_data;
        logic             full;
        logic             overrun;
    } dev_state_t;

    dev_state_t s_q;
    dev_state_t s_d;
    logic       cs_n_s;
    logic       wr_n_s;
    logic       sel_s;
    addr_t      addr_s;
    word_t      data_s;
    logic       now_active;
    logic       fifo_in_ready;

    // pins pass two flops before use
    assign {cs_n_s, wr_n_s, sel_s, addr_s, data_s} = s_q.sync2;

    always_comb begin
        s_d        = s_q;
        s_d.sync1  = {pins.chip_select_n, pins.write_strobe_n, pins.fifo_sel,
                      pins.addr, pins.data};
        s_d.sync2  = s_q.sync1;
        now_active = !cs_n_s && !wr_n_s;
        s_d.active = now_active;
        s_d.reg_wr = 1'b0;
        s_d.push   = 1'b0;
        s_d.full   = !fifo_in_ready;
        if (now_active) begin
            s_d.shadow = {sel_s, addr_s, data_s};
        end
        // either strobe rising ends the cycle, one commit per cycle
        if (s_q.active && !now_active) begin
            if (s_q.shadow[SH_W-1]) begin
                s_d.push_data = s_q.shadow[`PIO_DATA_W-1:0];
                if (fifo_in_ready) begin
                    s_d.push = 1'b1;
                end else begin
                    s_d.overrun = 1'b1;
                end
            end else begin
                s_d.reg_wr   = 1'b1;
                s_d.reg_addr = s_q.shadow[SH_W-2:`PIO_DATA_W];
                s_d.reg_data = s_q.shadow[`PIO_DATA_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q       <= '0;
            s_q.sync1 <= {2'b11, {(PIN_W-2){1'b0}}};
            s_q.sync2 <= {2'b11, {(PIN_W-2){1'b0}}};
        end else begin
            s_q <= s_d;
        end
    end

    tx_word_fifo #(
        .WIDTH (`PIO_DATA_W),
        .DEPTH (`PIO_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (s_q.push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (s_q.push_data),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i),
        .out_data_o  (tx_data_o)
    );

    assign reg_wr_o    = s_q.reg_wr;
    assign reg_addr_o  = s_q.reg_addr;
    assign reg_data_o  = s_q.reg_data;
    assign fifo_full_o = s_q.full;
    assign overrun_o   = s_q.overrun;
endmodule // pio_wr_device
`default_nettype wire

// [design/pio_wr_host.sv]
// host end of the write port: turns word requests into strobe cycles
`timescale 1ns/10ps
`default_nettype none
`include "pio_wr_map.svh"
module pio_wr_host (
    input  wire logic                sys_clk_i,
    input  wire logic                rst_b_i,
    pio_wr_if.host                   pins,
    input  wire logic                cmd_valid_i,
    output logic                     cmd_ready_o,
    input  wire logic                cmd_fifo_i,
    input  wire pio_wr_pkg::addr_t   cmd_addr_i,
    input  wire pio_wr_pkg::word_t   cmd_data_i
);
    import pio_wr_pkg::*;

    localparam int CSL_CYC = (`PIO_T_CSL_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS;
    localparam int CSH_CYC = (`PIO_T_CSH_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS;
    localparam int CYC_CYC = (`PIO_T_CYCLE_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS;
    localparam int REC_RAW = CYC_CYC - CSL_CYC - 1;
    localparam int REC_CYC = (REC_RAW > CSH_CYC) ? REC_RAW : CSH_CYC;
    localparam logic [3:0] CSL_LAST = 4'(CSL_CYC - 1);
    localparam logic [3:0] REC_LAST = 4'(REC_CYC - 1);

    typedef struct packed {
        host_state_t state;
        logic [3:0]  cnt;
        logic        cs_n;
        logic        wr_n;
        logic        sel;
        addr_t       addr;
        word_t       data;
        logic        ready;
    } host_reg_t;

    host_reg_t s_q;
    host_reg_t s_d;

    always_comb begin
        s_d       = s_q;
        s_d.ready = 1'b0;
        unique case (s_q.state)
            H_IDLE: begin
                if (cmd_valid_i && s_q.ready) begin
                    s_d.sel   = cmd_fifo_i;
                    s_d.addr  = cmd_addr_i;
                    s_d.data  = cmd_data_i;
                    s_d.state = H_SETUP;
                end else begin
                    s_d.ready = 1'b1;
                end
            end
            H_SETUP: begin
                s_d.cs_n  = 1'b0;
                s_d.wr_n  = 1'b0;
                s_d.cnt   = '0;
                s_d.state = H_STROBE;
            end
            H_STROBE: begin
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == CSL_LAST) begin
                    s_d.cs_n  = 1'b1;
                    s_d.wr_n  = 1'b1;
                    s_d.cnt   = '0;
                    s_d.state = H_RECOV;
                end
            end
            H_RECOV: begin
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == REC_LAST) begin
                    s_d.ready = 1'b1;
                    s_d.state = H_IDLE;
                end
            end
            default: begin
                s_d.state = H_IDLE;
                s_d.cs_n  = 1'b1;
                s_d.wr_n  = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q       <= '0;
            s_q.state <= H_IDLE;
            s_q.cs_n  <= 1'b1;
            s_q.wr_n  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pins.chip_select_n  = s_q.cs_n;
    assign pins.write_strobe_n = s_q.wr_n;
    assign pins.fifo_sel       = s_q.sel;
    assign pins.addr           = s_q.addr;
    assign pins.data           = s_q.data;
    assign cmd_ready_o         = s_q.ready;
endmodule // pio_wr_host
`default_nettype wire

// [include/pio_wr_if.sv]
// pin bundle between host and device
`timescale 1ns/10ps
`default_nettype none
interface pio_wr_if;
    import pio_wr_pkg::*;
    logic  chip_select_n;
    logic  write_strobe_n;
    logic  fifo_sel;
    addr_t addr;
    word_t data;
    modport host (output chip_select_n, output write_strobe_n, output fifo_sel,
                  output addr, output data);
    modport device (input chip_select_n, input write_strobe_n, input fifo_sel,
                    input addr, input data);
endinterface
`default_nettype wire

// [include/pio_wr_map.svh]
// constants of the host write port: widths, pin timing and clock rate
//
// Overview of operation
// - every host write uses one write cycle
// - cycle starts when both strobes low
// - cycle ends when either strobe rises
// - strobes high at least 13 ns between
// - strobes low 32 ns, cycles 165 ns apart
// - fifo select high sends word to fifo
// - fifo mode ignores the address inputs
// - fifo select timed like the address
// - sixteen bit data, one word per cycle
`ifndef PIO_WR_MAP_SVH
`define PIO_WR_MAP_SVH

// ************************************************************
// widths
// ************************************************************
`define PIO_DATA_W      16
`define PIO_ADDR_W      7
`define PIO_FIFO_DEPTH  8

// ************************************************************
// timing
// ************************************************************
`define PIO_CLK_NS      25
`define PIO_T_CSL_NS    32
`define PIO_T_CSH_NS    13
`define PIO_T_CYCLE_NS  165

`endif

// [include/pio_wr_pkg.sv]
// types of the host write port: word and address shared by both ends, state codes for the host end
`include "pio_wr_map.svh"
package pio_wr_pkg;
    typedef logic [`PIO_DATA_W-1:0] word_t;
    typedef logic [`PIO_ADDR_W-1:0] addr_t;
    typedef enum logic [3:0] {
        H_IDLE   = 4'h1,
        H_SETUP  = 4'h2,
        H_STROBE = 4'h4,
        H_RECOV  = 4'h8
    } host_state_t;
endpackage

// [verification/pio_wr_properties.sv]
// pin timing checks of the host write port
`timescale 1ns/10ps
`default_nettype none
module pio_wr_properties (
    input wire logic              sys_clk_i,
    input wire logic              rst_b_i,
    input wire logic              chip_select_n,
    input wire logic              write_strobe_n,
    input wire logic              fifo_sel,
    input wire pio_wr_pkg::addr_t addr,
    input wire pio_wr_pkg::word_t data
);
    import pio_wr_pkg::*;
    // ************************************************************
    // strobe cycle checks
    // ************************************************************
    wire logic act;
    assign act = !chip_select_n && !write_strobe_n;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    pair_start_a: assert property ($fell(chip_select_n) |-> $fell(write_strobe_n))
        else $error("strobes fell apart");
    low_time_a: assert property ($rose(act) |-> act[*2])
        else $error("strobes low too short");
    cycle_end_a: assert property ($rose(act) |-> ##[2:8] !act)
        else $error("cycle did not end");
    high_time_a: assert property ($fell(act) |=> !act)
        else $error("strobes high too short");
    cycle_spacing_a: assert property ($rose(act) |=> (!$rose(act))[*6])
        else $error("cycles too close");
    addr_held_a: assert property (
        $rose(act) |-> ($stable(addr) && $stable(fifo_sel)) throughout act[*2])
        else $error("address moved in cycle");
    data_held_a: assert property (act |-> $stable(data))
        else $error("data moved in cycle");
    release_hold_a: assert property ($fell(act) |-> $stable(data) && $stable(addr))
        else $error("data moved at cycle end");
    reg_c: cover property ($rose(act) && !fifo_sel);
    fifo_c: cover property ($rose(act) && fifo_sel);
    back_c: cover property ($rose(act) ##8 $rose(act));
endmodule // pio_wr_properties
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench: host end writes through the pins into the device end
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import pio_wr_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        cmd_valid_q = 1'b0;
    logic        cmd_fifo_q = 1'b0;
    addr_t       cmd_addr_q = '0;
    word_t       cmd_data_q = '0;
    logic        tx_ready_q = 1'b0;
    logic        cmd_ready, reg_wr, tx_valid, fifo_full, overrun;
    addr_t       reg_addr;
    word_t       reg_data, tx_data;
    int          errors = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          strobes = 0;
    logic [22:0] reg_q[$];
    word_t       tx_q[$];
    addr_t       ra[3] = '{7'h00, 7'h7F, 7'h2A};
    word_t       rd[3] = '{16'hFFFF, 16'h0000, 16'hA5C3};
    pio_wr_if pio_wr_if_i ();
    pio_wr_host pio_wr_host_i (
        .sys_clk_i   (sys_clk_i),
        .rst_b_i     (rst_b_i),
        .pins        (pio_wr_if_i.host),
        .cmd_valid_i (cmd_valid_q),
        .cmd_ready_o (cmd_ready),
        .cmd_fifo_i  (cmd_fifo_q),
        .cmd_addr_i  (cmd_addr_q),
        .cmd_data_i  (cmd_data_q)
    );
    pio_wr_device pio_wr_device_i (
        .sys_clk_i   (sys_clk_i),
        .rst_b_i     (rst_b_i),
        .pins        (pio_wr_if_i.device),
        .reg_wr_o    (reg_wr),
        .reg_addr_o  (reg_addr),
        .reg_data_o  (reg_data),
        .tx_valid_o  (tx_valid),
        .tx_ready_i  (tx_ready_q),
        .tx_data_o   (tx_data),
        .fifo_full_o (fifo_full),
        .overrun_o   (overrun)
    );
    pio_wr_properties pio_wr_properties_i (
        .sys_clk_i      (sys_clk_i),
        .rst_b_i        (rst_b_i),
        .chip_select_n  (pio_wr_if_i.chip_select_n),
        .write_strobe_n (pio_wr_if_i.write_strobe_n),
        .fifo_sel       (pio_wr_if_i.fifo_sel),
        .addr           (pio_wr_if_i.addr),
        .data           (pio_wr_if_i.data)
    );
    always #12.5 sys_clk_i = ~sys_clk_i;
    // ************************************************************
    // monitor and watchdog
    // ************************************************************
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            errors++;
            test_done();
        end
        if (reg_wr === 1'b1) reg_q.push_back({reg_addr, reg_data});
        if (tx_valid === 1'b1 && tx_ready_q === 1'b1) tx_q.push_back(tx_data);
        if ($fell(pio_wr_if_i.chip_select_n)) strobes++;
    end
    task automatic check(input string name, input logic [22:0] seen, input logic [22:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    // valid stays up after the take so that requests can follow back to back
    task automatic send(input logic f, input addr_t a, input word_t d);
        int n;
        n = 0;
        cmd_fifo_q <= f;
        cmd_addr_q <= a;
        cmd_data_q <= d;
        cmd_valid_q <= 1'b1;
        @(posedge sys_clk_i);
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(posedge sys_clk_i);
            n++;
        end
        check("request taken", cmd_ready, 1'b1);
    endtask
    task automatic test_done();
        $display("comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ************************************************************
    // stimulus
    // ************************************************************
    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        // register writes back to back with boundary values
        for (int i = 0; i < 3; i++) send(1'b0, ra[i], rd[i]);
        cmd_valid_q <= 1'b0;
        repeat (12) @(posedge sys_clk_i);
        check("register writes", reg_q.size(), 3);
        check("strobe cycles", strobes, 3);
        for (int i = 0; i < 3; i++) check("register word", reg_q[i], {ra[i], rd[i]});
        check("fifo idle", tx_valid, 1'b0);
        check("fifo not full", fifo_full, 1'b0);
        check("no overrun", overrun, 1'b0);
        // fifo writes with changing addresses while the drain stalls
        for (int i = 0; i < 10; i++) send(1'b1, 7'(i * 13), 16'h1000 + 16'(i));
        cmd_valid_q <= 1'b0;
        repeat (12) @(posedge sys_clk_i);
        check("register writes", reg_q.size(), 3);
        check("fifo full", fifo_full, 1'b1);
        check("overrun", overrun, 1'b1);
        tx_ready_q <= 1'b1;
        repeat (15) @(posedge sys_clk_i);
        check("fifo words", tx_q.size(), 9);
        for (int i = 0; i < 9; i++) check("fifo word", tx_q[i], 16'h1000 + 16'(i));
        check("drained valid", tx_valid, 1'b0);
        check("drained full", fifo_full, 1'b0);
        test_done();
    end
endmodule // testbench
`default_nettype wire
